// ===== design/xff_fabric_if.sv
module xff_fabric_if #(
  parameter int DATA_W = xff_pkg::DATA_W,
  parameter int DEPTH = xff_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rxDigitalReset,
  input wire logic txDigitalReset,
  input wire logic pipeMode,
  input wire logic lineSignalPresent,
  output logic rxSignalPresent,
  input wire logic rxFaultEnable,
  input wire logic txFaultEnable,
  output logic rxFifoFault,
  output logic txFifoFault,
  input wire logic calBlkPowerdown_n,
  output logic calBlkActive,
  input wire logic pcsRxValid,
  output logic pcsRxReady,
  input wire logic [DATA_W-1:0] pcsRxData,
  output logic fabRxValid,
  input wire logic fabRxReady,
  output logic [DATA_W-1:0] fabRxData,
  input wire logic fabTxValid,
  output logic fabTxReady,
  input wire logic [DATA_W-1:0] fabTxData,
  output logic pcsTxValid,
  input wire logic pcsTxReady,
  output logic [DATA_W-1:0] pcsTxData
);
  // ------------------------------------------------------------
  // resets and line sampling
  // ------------------------------------------------------------
  // one fabric clock serves both fifo sides; zero ppm by construction
  wire rxReset = reset || rxDigitalReset;
  wire txReset = reset || txDigitalReset;
  logic sigSync1_r;
  logic sigSync2_r;
  logic calSync1_r;
  logic calSync2_r;
  logic rxSignalPresent_r;
  logic calBlkActive_r;
  logic rxFifoFault_r;
  logic txFifoFault_r;
  logic rxOvf;
  logic rxUnd;
  logic txOvf;
  logic txUnd;
  logic [DATA_W-1:0] rxQ;
  logic [DATA_W-1:0] txQ;
  logic rxQValid;
  logic txQValid;

  always_ff @(posedge sys_clk) begin
    sigSync1_r <= lineSignalPresent;
    sigSync2_r <= sigSync1_r;
    calSync1_r <= calBlkPowerdown_n;
    calSync2_r <= calSync1_r;
  end

  // ------------------------------------------------------------
  // signal presence
  // ------------------------------------------------------------
  // outside pipe mode the detector is bypassed, so the flag carries no meaning
  wire sigPresentNxt = pipeMode ? sigSync2_r : xff_pkg::SIGDET_FORCED;

  always_ff @(posedge sys_clk) begin
    if (rxReset) begin
      rxSignalPresent_r <= xff_pkg::SIGDET_FORCED;
    end else begin
      rxSignalPresent_r <= sigPresentNxt;
    end
  end

  // ------------------------------------------------------------
  // calibration block power-down
  // ------------------------------------------------------------
  // while powered down both fifos are stalled: traffic may stop
  wire calDown = (calSync2_r == xff_pkg::CAL_PD_ACTIVE);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      calBlkActive_r <= 1'b0;
    end else begin
      calBlkActive_r <= !calDown;
    end
  end

  // ------------------------------------------------------------
  // phase compensation fifos
  // ------------------------------------------------------------
  wire rxInValid = pcsRxValid && !calDown;
  wire rxOutReady = fabRxReady && !calDown;
  wire txInValid = fabTxValid && !calDown;
  wire txOutReady = pcsTxReady && !calDown;
  logic rxInReady;
  logic txInReady;

  xff_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxFifo (
    .sys_clk(sys_clk),
    .reset(rxReset),
    .inValid(rxInValid),
    .inReady(rxInReady),
    .inData(pcsRxData),
    .outValid(rxQValid),
    .outReady(rxOutReady),
    .outData(rxQ),
    .overflow(rxOvf),
    .underrun(rxUnd)
  );

  xff_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txFifo (
    .sys_clk(sys_clk),
    .reset(txReset),
    .inValid(txInValid),
    .inReady(txInReady),
    .inData(fabTxData),
    .outValid(txQValid),
    .outReady(txOutReady),
    .outData(txQ),
    .overflow(txOvf),
    .underrun(txUnd)
  );

  assign pcsRxReady = rxInReady && !calDown;
  assign fabTxReady = txInReady && !calDown;
  assign fabRxValid = rxQValid && !calDown;
  assign fabRxData = rxQ;
  assign pcsTxValid = txQValid && !calDown;
  assign pcsTxData = txQ;

  // ------------------------------------------------------------
  // fault flags
  // ------------------------------------------------------------
  // registered one cycle after the event, high one cycle per event
  wire rxFaultNxt = rxFaultEnable && (rxOvf || rxUnd);
  wire txFaultNxt = txFaultEnable && (txOvf || txUnd);

  always_ff @(posedge sys_clk) begin
    if (rxReset) begin
      rxFifoFault_r <= xff_pkg::FAULT_CLEAR;
    end else begin
      rxFifoFault_r <= rxFaultNxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (txReset) begin
      txFifoFault_r <= xff_pkg::FAULT_CLEAR;
    end else begin
      txFifoFault_r <= txFaultNxt;
    end
  end

  assign rxSignalPresent = rxSignalPresent_r;
  assign calBlkActive = calBlkActive_r;
  assign rxFifoFault = rxFifoFault_r;
  assign txFifoFault = txFifoFault_r;
endmodule

// ===== design/xff_fifo.sv
// ------------------------------------------------------------
// phase compensation fifo with overflow / underrun flags
// ------------------------------------------------------------
module xff_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic overflow,
  output logic underrun
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire full = (count_r == (AW+1)'(DEPTH));
  wire empty = (count_r == '0);
  wire doWrite = inValid && !full;
  wire doRead = outReady && !empty;
  wire [AW-1:0] wrPtrNxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
  wire [AW-1:0] rdPtrNxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem_r[rdPtr_r];
  // attempts against full/empty are the fault events
  assign overflow = inValid && full;
  assign underrun = outReady && empty;

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWrite) wrPtr_r <= wrPtrNxt;
      if (doRead) rdPtr_r <= rdPtrNxt;
      count_r <= count_r + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

// ===== design/xff_pkg.sv
package xff_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int SIGDET_SYNC_STAGES = 2;
  localparam logic FAULT_CLEAR = 1'b0;
  localparam logic SIGDET_FORCED = 1'b1;
  localparam logic CAL_PD_ACTIVE = 1'b0;
endpackage

// ===== verification/testbench.sv
module testbench;
  timeunit 1ns / 1ps;
  logic sys_clk = 0, reset = 1, rxDigitalReset = 0, txDigitalReset = 0, pipeMode = 0, lineSignalPresent = 0;
  logic rxFaultEnable = 1, txFaultEnable = 1, calBlkPowerdown_n = 1, pcsRxValid = 0, fabRxReady = 0;
  logic pcsTxReady = 0, sendEn = 0, rxSignalPresent, rxFifoFault, txFifoFault, calBlkActive, pcsRxReady;
  logic fabRxValid, fabTxValid, fabTxReady, pcsTxValid;
  logic [xff_pkg::DATA_W-1:0] pcsRxData = 16'h0000, fabRxData, fabTxData, pcsTxData;
  int n_fail = 0, checks_done = 0, cyc = 0;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 900) begin
    n_fail++;
    end_of_test();
  end
  // this single instance owns the calibration block
  xff_fabric_if dut (.*);
  xff_fab_model partner (.*);
  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    step(4);
    reset = 0;
    `CHK({rxFifoFault, txFifoFault, rxSignalPresent, calBlkActive, fabRxValid}, 5'b00100)
    step(5);
    `CHK({calBlkActive, rxSignalPresent}, 2'b11)
    pipeMode = 1;
    step(4);
    `CHK(rxSignalPresent, 1'b0)
    lineSignalPresent = 1;
    step(4);
    `CHK(rxSignalPresent, 1'b1)
    pcsRxValid = 1;
    for (int i = 0; i < 9; i++) begin
      pcsRxData = 16'hA000 + 16'(i);
      step(1);
    end
    `CHK({pcsRxReady, rxFifoFault}, 2'b01)
    pcsRxValid = 0;
    fabRxReady = 1;
    for (int i = 0; i < 8; i++) begin
      `CHK({fabRxValid, fabRxData}, {1'b1, 16'hA000 + 16'(i)})
      step(1);
    end
    step(1);
    `CHK(rxFifoFault, 1'b1)
    fabRxReady = 0;
    sendEn = 1;
    step(9);
    `CHK({fabTxReady, txFifoFault}, 2'b01)
    sendEn = 0;
    pcsTxReady = 1;
    for (int i = 0; i < 8; i++) begin
      `CHK({pcsTxValid, pcsTxData}, {1'b1, 16'h5A00 + 16'(i)})
      step(1);
    end
    step(1);
    `CHK(txFifoFault, 1'b1)
    pcsTxReady = 0;
    pcsRxValid = 1;
    sendEn = 1;
    step(1);
    {pcsRxValid, sendEn, rxDigitalReset, txDigitalReset} = 4'b0011;
    step(1);
    `CHK({fabRxValid, pcsTxValid, rxFifoFault, txFifoFault}, 4'b0000)
    {rxDigitalReset, txDigitalReset} = 2'b00;
    // recalibration pulse, long enough to pass the synchroniser
    calBlkPowerdown_n = 0;
    step(5);
    `CHK({calBlkActive, pcsRxReady}, 2'b00)
    calBlkPowerdown_n = 1;
    step(5);
    `CHK(calBlkActive, 1'b1)
    // disabled flags must stay quiet on an underrun attempt
    {rxFaultEnable, txFaultEnable, fabRxReady, pcsTxReady} = 4'b0011;
    step(2);
    `CHK(rxFifoFault, 1'b0)
    `CHK(txFifoFault, 1'b0)
    {rxFaultEnable, txFaultEnable, fabRxReady, pcsTxReady} = 4'b1100;
    step(1);
    end_of_test();
  end
endmodule

// ===== verification/xff_fab_model.sv
module xff_fab_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sendEn,
  input wire logic fabTxReady,
  output logic fabTxValid,
  output logic [xff_pkg::DATA_W-1:0] fabTxData
);
  timeunit 1ns / 1ps;
  logic [xff_pkg::DATA_W-1:0] word_r;
  // same clock as the pcs side, so zero ppm offset
  // presence flag unused: meaningless outside pipe mode
  // fault flags only observed by checks, never steer traffic
  assign fabTxValid = sendEn;
  // idle bus shows the inverse so a stale word never looks valid
  assign fabTxData = sendEn ? word_r : ~word_r;
  always_ff @(posedge sys_clk)
    if (reset) word_r <= 16'h5A00;
    else if (fabTxValid && fabTxReady) word_r <= word_r + 16'h0001;
endmodule

// ===== verification/xff_props.sv
module xff_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rxDigitalReset,
  input wire logic txDigitalReset,
  input wire logic pipeMode,
  input wire logic rxFaultEnable,
  input wire logic txFaultEnable,
  input wire logic rxSignalPresent,
  input wire logic rxFifoFault,
  input wire logic txFifoFault,
  input wire logic calBlkPowerdown_n,
  input wire logic calBlkActive,
  input wire logic pcsRxValid,
  input wire logic pcsRxReady,
  input wire logic fabRxValid,
  input wire logic fabRxReady,
  input wire logic fabTxValid,
  input wire logic fabTxReady,
  input wire logic pcsTxValid,
  input wire logic pcsTxReady
);
  timeunit 1ns / 1ps;
  default clocking @(posedge sys_clk); endclocking
  // traffic stalls while calibration is down, so fifo checks pause too
  default disable iff (reset || !calBlkActive);
  property p_pres; !pipeMode |-> rxSignalPresent; endproperty
  a_pres: assert property (p_pres) else $error("presence low");
  property p_rxOv; rxFaultEnable && pcsRxValid && !pcsRxReady |=> rxFifoFault; endproperty
  a_rxOv: assert property (p_rxOv) else $error("rx overflow");
  property p_rxUn; rxFaultEnable && fabRxReady && !fabRxValid |=> rxFifoFault; endproperty
  a_rxUn: assert property (p_rxUn) else $error("rx underrun");
  property p_txOv; txFaultEnable && fabTxValid && !fabTxReady |=> txFifoFault; endproperty
  a_txOv: assert property (p_txOv) else $error("tx overflow");
  property p_txUn; txFaultEnable && pcsTxReady && !pcsTxValid |=> txFifoFault; endproperty
  a_txUn: assert property (p_txUn) else $error("tx underrun");
  property p_rxRst; rxDigitalReset |=> !rxFifoFault && !fabRxValid; endproperty
  a_rxRst: assert property (p_rxRst) else $error("rx reset");
  property p_txRst; txDigitalReset |=> !txFifoFault && !pcsTxValid; endproperty
  a_txRst: assert property (p_txRst) else $error("tx reset");
  property p_cal; disable iff (reset) !calBlkPowerdown_n [*5] |-> !calBlkActive; endproperty
  a_cal: assert property (p_cal) else $error("cal active");
endmodule
bind xff_fabric_if xff_props u_props (.*);
